//--- shared/msc_pkg.sv
// Purpose: Constants and types for the module sideband control block
// Assumes: System clock of 25 MHz; 2-wire target behind the module select pin
// Notes on behaviour
// - Answer 2-wire transactions only while module select is held low.
// - Reset pin low past minimum pulse length restores all settings to defaults.
// - Reset completion raises interrupt with the not-ready flag cleared.
// - Power-up raises the reset-completion interrupt without any host reset.
// - Low-power select input limits the maximum power consumption.
// - Interrupt pin pulled low to report faults or critical conditions.
// - Interrupt pin is open-drain: pulled low or released only.
// - Seven low-speed control pins, including the two serial bus lines.

package msc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESET_MIN_NS  = 10000;
    localparam int INIT_NS       = 4000;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CYC      = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 12;

    // ------------------------------------------------------------
    // Serial target
    // ------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR = 7'h50;
    localparam logic [3:0] BITS_BYTE   = 4'h8;

    // ------------------------------------------------------------
    // Management memory
    // ------------------------------------------------------------
    localparam logic [7:0] MEM_STATUS   = 8'h00;
    localparam logic [7:0] MEM_CONTROL  = 8'h01;
    localparam int         ST_NOT_READY = 0;
    localparam int         ST_DONE      = 1;
    localparam int         ST_FAULT     = 2;
    localparam int         ST_LOW_POWER = 3;
    localparam int         CT_FORCE_LP  = 0;
    localparam logic [7:0] CONTROL_RST  = 8'h00;

    typedef enum logic [0:0] {MSC_INIT, MSC_READY} msc_life_type;

    typedef enum logic [2:0] {
        TW_IDLE, TW_ADDR, TW_ACK_ADDR, TW_WRITE, TW_ACK_WRITE, TW_READ, TW_ACK_READ
    } msc_twi_type;

endpackage

//--- core/msc_twi_target.sv
// Purpose: 2-wire serial target with a byte pointer into the management memory
// Assumes: scl and sda already synchronised to clk; hold is same-clock logic
// Notes: Drives sda_oe only for acknowledge and read data bits
`timescale 1ns/10ps
`default_nettype none

module msc_twi_target
    import msc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Bus lines and gating
    input  wire logic       hold,
    input  wire logic       scl,
    input  wire logic       sda,
    output var  logic       sda_oe,
    // Memory access
    input  wire logic [7:0] rd_data,
    output var  logic [7:0] ptr,
    output var  logic       rd_take,
    output var  logic       wr_stb,
    output var  logic [7:0] wr_data
);

    msc_twi_type state;
    logic        scl_d;
    logic        sda_d;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic        is_read;
    logic        first;
    logic        nack;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_cond;
    logic        stop_cond;

    assign scl_rise   = scl & ~scl_d;
    assign scl_fall   = ~scl & scl_d;
    assign start_cond = scl & scl_d & sda_d & ~sda;
    assign stop_cond  = scl & scl_d & ~sda_d & sda;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= TW_IDLE;
            sda_oe  <= 1'b0;
            bit_cnt <= 4'h0;
            shreg   <= 8'h00;
            is_read <= 1'b0;
            first   <= 1'b0;
            nack    <= 1'b0;
            ptr     <= 8'h00;
            rd_take <= 1'b0;
            wr_stb  <= 1'b0;
            wr_data <= 8'h00;
        end else begin
            rd_take <= 1'b0;
            wr_stb  <= 1'b0;
            if (hold) begin
                state  <= TW_IDLE;
                sda_oe <= 1'b0;
            end else if (start_cond) begin
                state   <= TW_ADDR;
                sda_oe  <= 1'b0;
                bit_cnt <= 4'h0;
                first   <= 1'b1;
            end else if (stop_cond) begin
                state  <= TW_IDLE;
                sda_oe <= 1'b0;
            end else begin
                unique case (state)
                    TW_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    TW_ADDR, TW_WRITE: begin
                        if (scl_rise) begin
                            shreg   <= {shreg[6:0], sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == BITS_BYTE) begin
                            if (state == TW_ADDR) begin
                                if (shreg[7:1] == TARGET_ADDR) begin
                                    state   <= TW_ACK_ADDR;
                                    sda_oe  <= 1'b1;
                                    is_read <= shreg[0];
                                end else begin
                                    state <= TW_IDLE;
                                end
                            end else begin
                                state  <= TW_ACK_WRITE;
                                sda_oe <= 1'b1;
                                if (first) begin
                                    ptr <= shreg;
                                end else begin
                                    wr_stb  <= 1'b1;
                                    wr_data <= shreg;
                                end
                            end
                        end
                    end
                    TW_ACK_ADDR, TW_ACK_WRITE: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            // Pointer byte itself does not advance the pointer
                            if (state == TW_ACK_WRITE) begin
                                first <= 1'b0;
                                if (!first) begin
                                    ptr <= ptr + 8'h01;
                                end
                            end
                            if (state == TW_ACK_ADDR && is_read) begin
                                state   <= TW_READ;
                                shreg   <= rd_data;
                                sda_oe  <= ~rd_data[7];
                                rd_take <= 1'b1;
                            end else begin
                                state  <= TW_WRITE;
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    TW_READ: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == BITS_BYTE) begin
                                state  <= TW_ACK_READ;
                                sda_oe <= 1'b0;
                                ptr    <= ptr + 8'h01;
                            end else begin
                                shreg  <= {shreg[6:0], 1'b0};
                                sda_oe <= ~shreg[6];
                            end
                        end
                    end
                    TW_ACK_READ: begin
                        if (scl_rise) begin
                            nack <= sda;
                        end else if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (nack) begin
                                state <= TW_IDLE;
                            end else begin
                                state   <= TW_READ;
                                shreg   <= rd_data;
                                sda_oe  <= ~rd_data[7];
                                rd_take <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        state  <= TW_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_hold_quiet;
        @(posedge clk) disable iff (!rst_n)
        hold |=> (state == TW_IDLE) && !sda_oe && !wr_stb;
    endproperty
    a_hold_quiet: assert property (p_hold_quiet)
        else $error("target active while deselected");

endmodule // msc_twi_target

`default_nettype wire

//--- core/msc_sideband.sv
// Purpose: Sideband control pins of a pluggable transceiver module
// Assumes: All pins asynchronous to CLK_SYS; FAULT_EVENT and INIT logic on CLK_SYS
// Notes: Open-drain pins shown as output value plus output enable
`timescale 1ns/10ps
`default_nettype none

module msc_sideband
    import msc_pkg::*;
(
    // Clock and reset
    input  wire logic CLK_SYS,
    input  wire logic RST_N,
    // Host control pins
    input  wire logic MODULE_SELECT_N,
    input  wire logic MODULE_RESET_N,
    input  wire logic LOW_POWER_SELECT,
    // 2-wire serial bus
    input  wire logic SCL_IN,
    input  wire logic SDA_IN,
    output var  logic SDA_OUT,
    output var  logic SDA_OE,
    // Presence and interrupt pins
    output var  logic PRESENCE_N,
    output var  logic ALERT_OUT_N_OUT,
    output var  logic ALERT_OUT_N_OE,
    // Module-internal status and control
    input  wire logic FAULT_EVENT,
    output var  logic DATA_NOT_READY,
    output var  logic POWER_HIGH_EN,
    output var  logic SETTINGS_RESET
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 5;

    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic             sel_n_s;
    logic             mrst_n_s;
    logic             lp_s;
    logic             scl_s;
    logic             sda_s;

    assign pin_raw = {MODULE_SELECT_N, MODULE_RESET_N, LOW_POWER_SELECT, SCL_IN, SDA_IN};
    assign {sel_n_s, mrst_n_s, lp_s, scl_s, sda_s} = sync2;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always_ff @(posedge CLK_SYS or negedge RST_N) begin
                if (!RST_N) begin
                    sync1[gi] <= 1'b1;
                    sync2[gi] <= 1'b1;
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Reset pulse qualification and initialisation
    // ------------------------------------------------------------
    msc_life_type     state;
    logic [CNT_W-1:0] rst_cnt;
    logic [CNT_W-1:0] init_cnt;
    logic             soft_rst;
    logic             init_end;

    assign soft_rst = !mrst_n_s && (rst_cnt == CNT_W'(RESET_MIN_CYC - 1));
    assign init_end = (state == MSC_INIT) && (init_cnt == CNT_W'(INIT_CYC - 1));

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_cnt <= '0;
        end else if (mrst_n_s) begin
            rst_cnt <= '0;
        end else if (rst_cnt != CNT_W'(RESET_MIN_CYC - 1)) begin
            rst_cnt <= rst_cnt + CNT_W'(1);
        end
    end

    // Power-up starts in INIT so completion is posted unprompted
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state    <= MSC_INIT;
            init_cnt <= '0;
        end else if (soft_rst) begin
            state    <= MSC_INIT;
            init_cnt <= '0;
        end else if (init_end) begin
            state <= MSC_READY;
        end else if (state == MSC_INIT) begin
            init_cnt <= init_cnt + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Serial target and management memory
    // ------------------------------------------------------------
    logic       twi_oe;
    logic [7:0] ptr;
    logic       rd_take;
    logic       wr_stb;
    logic [7:0] wr_data;
    logic [7:0] control;
    logic       done_flag;
    logic       fault_flag;
    logic       status_read;

    function automatic logic [7:0] mem_read(input logic [7:0] a, input logic [7:0] st,
                                            input logic [7:0] ct);
        if (a == MEM_STATUS) begin
            return st;
        end else if (a == MEM_CONTROL) begin
            return ct;
        end else begin
            return 8'h00;
        end
    endfunction

    logic [7:0] status_byte;
    always_comb begin
        status_byte               = 8'h00;
        status_byte[ST_NOT_READY] = DATA_NOT_READY;
        status_byte[ST_DONE]      = done_flag;
        status_byte[ST_FAULT]     = fault_flag;
        status_byte[ST_LOW_POWER] = ~POWER_HIGH_EN;
    end

    msc_twi_target u_twi (
        .clk     (CLK_SYS),
        .rst_n   (RST_N),
        .hold    (sel_n_s),
        .scl     (scl_s),
        .sda     (sda_s),
        .sda_oe  (twi_oe),
        .rd_data (mem_read(ptr, status_byte, control)),
        .ptr     (ptr),
        .rd_take (rd_take),
        .wr_stb  (wr_stb),
        .wr_data (wr_data)
    );

    assign status_read = rd_take && (ptr == MEM_STATUS);

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            control <= CONTROL_RST;
        end else if (soft_rst) begin
            control <= CONTROL_RST;
        end else if (wr_stb && ptr == MEM_CONTROL) begin
            control <= wr_data;
        end
    end

    // Flags: a setting event wins over a clearing status read
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            done_flag  <= 1'b0;
            fault_flag <= 1'b0;
        end else begin
            if (soft_rst) begin
                done_flag <= 1'b0;
            end else if (init_end) begin
                done_flag <= 1'b1;
            end else if (status_read) begin
                done_flag <= 1'b0;
            end
            if (soft_rst) begin
                fault_flag <= 1'b0;
            end else if (FAULT_EVENT) begin
                fault_flag <= 1'b1;
            end else if (status_read) begin
                fault_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin and status outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            DATA_NOT_READY <= 1'b1;
        end else if (soft_rst) begin
            DATA_NOT_READY <= 1'b1;
        end else if (init_end) begin
            DATA_NOT_READY <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            SDA_OUT         <= 1'b0;
            SDA_OE          <= 1'b0;
            PRESENCE_N      <= 1'b0;
            ALERT_OUT_N_OUT <= 1'b0;
            ALERT_OUT_N_OE  <= 1'b0;
            POWER_HIGH_EN   <= 1'b0;
            SETTINGS_RESET  <= 1'b1;
        end else begin
            SDA_OUT         <= 1'b0;
            SDA_OE          <= twi_oe & ~sel_n_s;
            PRESENCE_N      <= 1'b0;
            ALERT_OUT_N_OUT <= 1'b0;
            ALERT_OUT_N_OE  <= (state == MSC_READY) && (done_flag || fault_flag);
            POWER_HIGH_EN   <= !lp_s && !control[CT_FORCE_LP] && (state == MSC_READY);
            SETTINGS_RESET  <= (state == MSC_INIT);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_sel_quiet;
        @(posedge CLK_SYS) disable iff (!RST_N)
        sel_n_s |=> !SDA_OE;
    endproperty
    a_sel_quiet: assert property (p_sel_quiet)
        else $error("data line driven while deselected");

    property p_reset_restart;
        @(posedge CLK_SYS) disable iff (!RST_N)
        soft_rst |=> (state == MSC_INIT) && DATA_NOT_READY && (control == CONTROL_RST);
    endproperty
    a_reset_restart: assert property (p_reset_restart)
        else $error("long reset pulse did not restore defaults");

    property p_short_pulse;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (state == MSC_READY && $rose(mrst_n_s)) |-> $past(state) == MSC_READY;
    endproperty
    a_short_pulse: assert property (p_short_pulse)
        else $error("reset state left unexpectedly");

    property p_done_alert;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (init_end && !FAULT_EVENT) |=> !DATA_NOT_READY ##1 (ALERT_OUT_N_OE || !done_flag);
    endproperty
    a_done_alert: assert property (p_done_alert)
        else $error("reset completion not posted");

    property p_init_quiet;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (state == MSC_INIT) |-> DATA_NOT_READY ##1 !ALERT_OUT_N_OE;
    endproperty
    a_init_quiet: assert property (p_init_quiet)
        else $error("interrupt or ready shown during initialisation");

    property p_low_power;
        @(posedge CLK_SYS) disable iff (!RST_N)
        lp_s |=> !POWER_HIGH_EN;
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("high power allowed in low-power mode");

    property p_fault_alert;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (FAULT_EVENT && state == MSC_READY && !soft_rst) |=> ##1 ALERT_OUT_N_OE;
    endproperty
    a_fault_alert: assert property (p_fault_alert)
        else $error("fault did not pull interrupt low");

    property p_open_drain;
        @(posedge CLK_SYS) disable iff (!RST_N)
        !ALERT_OUT_N_OUT && !SDA_OUT;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin driven high");

endmodule // msc_sideband

`default_nettype wire

//--- sim/msc_host.sv
// Purpose: Host board model driving select and the 2-wire bus
// Assumes: Pulled-up lines resolved in the bench; SCL period 8 clocks
// Notes: SCL idles high between frames
`timescale 1ns/10ps
`default_nettype none

module msc_host
    import msc_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Lines seen
    input  wire logic sda_line,
    input  wire logic presence_line,
    // Lines driven
    output var  logic scl,
    output var  logic sda_low,
    output var  logic select_n,
    output var  logic present
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        select_n = 1'b1; // Own select line for this module
    end

    assign present = (presence_line === 1'b0); // Low means inserted

    // ------------------------------------------------------------
    // Bit level
    // ------------------------------------------------------------
    task automatic put_bit(input logic b, output logic seen);
        scl <= 1'b0;
        repeat (2) @(posedge clk);
        sda_low <= ~b;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk) seen = sda_line;
        @(posedge clk);
    endtask

    task automatic frame_start;
        sda_low <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic frame_stop;
        scl <= 1'b0;
        repeat (2) @(posedge clk);
        sda_low <= 1'b1;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_low <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Byte level
    // ------------------------------------------------------------
    task automatic send_byte(input logic [7:0] d, output logic ack_n);
        logic dummy;
        for (int i = 7; i >= 0; i--) put_bit(d[i], dummy);
        put_bit(1'b1, ack_n);
    endtask

    task automatic get_byte(output logic [7:0] d);
        logic dummy;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
        put_bit(1'b1, dummy);
    endtask

    // ------------------------------------------------------------
    // Transactions
    // ------------------------------------------------------------
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, input logic sel,
                             output logic ack_n);
        logic a0, a1, a2;
        select_n <= sel;
        repeat (4) @(posedge clk);
        frame_start();
        send_byte({TARGET_ADDR, 1'b0}, a0);
        send_byte(ptr, a1);
        send_byte(d, a2);
        frame_stop();
        select_n <= 1'b1;
        @(posedge clk);
        ack_n = a0 | a1 | a2;
    endtask

    // Pointer write frame, stop, then a one-byte read frame ended with a not-acknowledge
    task automatic read_reg(input logic [7:0] ptr, input logic sel, output logic [7:0] d,
                            output logic ack_n);
        logic a0, a1, a2;
        select_n <= sel;
        repeat (4) @(posedge clk);
        frame_start();
        send_byte({TARGET_ADDR, 1'b0}, a0);
        send_byte(ptr, a1);
        frame_stop();
        frame_start();
        send_byte({TARGET_ADDR, 1'b1}, a2);
        get_byte(d);
        frame_stop();
        select_n <= 1'b1;
        @(posedge clk);
        ack_n = a0 | a1 | a2;
    endtask
endmodule // msc_host

`default_nettype wire

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the sideband control block
// Assumes: Open-drain lines pulled up here
// Notes: Serial traffic through the host model tasks
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import msc_pkg::*;

    logic       clk_sys, rst_n, module_reset_n, low_power_select, fault_event;
    logic       scl, sda_low, select_n, present, sda_out, sda_oe, presence_n;
    logic       alert_out, alert_oe, data_not_ready, power_high_en, settings_reset;
    logic [7:0] rd;
    logic       ack_n;
    int         num_errors = 0;
    int         n_tests = 0;
    wire        sda_line;
    wire        alert_line;

    assign sda_line   = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    assign alert_line = (alert_oe && !alert_out) ? 1'b0 : 1'b1;

    // ------------------------------------------------------------
    // Clock and instances
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    msc_sideband u_msc_sideband (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .MODULE_SELECT_N(select_n),
        .MODULE_RESET_N(module_reset_n), .LOW_POWER_SELECT(low_power_select),
        .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .PRESENCE_N(presence_n), .ALERT_OUT_N_OUT(alert_out), .ALERT_OUT_N_OE(alert_oe),
        .FAULT_EVENT(fault_event), .DATA_NOT_READY(data_not_ready),
        .POWER_HIGH_EN(power_high_en), .SETTINGS_RESET(settings_reset)
    );

    msc_host u_msc_host (
        .clk(clk_sys), .sda_line(sda_line), .presence_line(presence_n), .scl(scl),
        .sda_low(sda_low), .select_n(select_n), .present(present)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_ready;
        int k;
        k = 0;
        while (data_not_ready !== 1'b0 && k < 300) begin
            @(posedge clk_sys);
            k++;
        end
    endtask

    task automatic wrap_up;
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        module_reset_n = 1'b1;
        low_power_select = 1'b0;
        fault_event = 1'b0;
        repeat (5) @(posedge clk_sys);
        check({7'h00, data_not_ready}, 8'h01);
        check({7'h00, alert_line}, 8'h01);
        check({7'h00, present}, 8'h01);
        rst_n <= 1'b1;
        wait_ready();
        check({7'h00, data_not_ready}, 8'h00);
        repeat (3) @(posedge clk_sys);
        check({7'h00, alert_line}, 8'h00);
        check({7'h00, alert_out}, 8'h00);
        check({7'h00, power_high_en}, 8'h01);
        u_msc_host.read_reg(MEM_STATUS, 1'b0, rd, ack_n);
        check({7'h00, ack_n}, 8'h00);
        check(rd, 8'h02);
        repeat (4) @(posedge clk_sys);
        check({7'h00, alert_line}, 8'h01);
        u_msc_host.read_reg(MEM_STATUS, 1'b1, rd, ack_n);
        check({7'h00, ack_n}, 8'h01);
        check(rd, 8'hFF);
        fault_event <= 1'b1;
        @(posedge clk_sys);
        fault_event <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check({7'h00, alert_line}, 8'h00);
        u_msc_host.read_reg(MEM_STATUS, 1'b0, rd, ack_n);
        check(rd, 8'h04);
        repeat (4) @(posedge clk_sys);
        check({7'h00, alert_line}, 8'h01);
        low_power_select <= 1'b1;
        repeat (5) @(posedge clk_sys);
        check({7'h00, power_high_en}, 8'h00);
        u_msc_host.read_reg(MEM_STATUS, 1'b0, rd, ack_n);
        check(rd, 8'h08);
        low_power_select <= 1'b0;
        repeat (5) @(posedge clk_sys);
        check({7'h00, power_high_en}, 8'h01);
        u_msc_host.write_reg(MEM_CONTROL, 8'h01, 1'b0, ack_n);
        check({7'h00, ack_n}, 8'h00);
        repeat (2) @(posedge clk_sys);
        check({7'h00, power_high_en}, 8'h00);
        module_reset_n <= 1'b0;
        repeat (100) @(posedge clk_sys);
        module_reset_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        check({7'h00, settings_reset}, 8'h00);
        u_msc_host.read_reg(MEM_CONTROL, 1'b0, rd, ack_n);
        check(rd, 8'h01);
        module_reset_n <= 1'b0;
        repeat (RESET_MIN_CYC + 10) @(posedge clk_sys);
        check({7'h00, settings_reset}, 8'h01);
        check({7'h00, data_not_ready}, 8'h01);
        check({7'h00, alert_line}, 8'h01);
        module_reset_n <= 1'b1;
        wait_ready();
        repeat (3) @(posedge clk_sys);
        check({7'h00, alert_line}, 8'h00);
        check({7'h00, power_high_en}, 8'h01);
        u_msc_host.read_reg(MEM_CONTROL, 1'b0, rd, ack_n);
        check(rd, 8'h00);
        u_msc_host.read_reg(MEM_STATUS, 1'b0, rd, ack_n);
        check(rd, 8'h02);
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
